//--- spi_baud_pkg.sv
// constants for the serial baud and status block
package spi_baud_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFS_CONTROL_ONE = 3'h0;
  localparam logic [2:0] OFS_CONTROL_TWO = 3'h1;
  localparam logic [2:0] OFS_BAUD = 3'h2;
  localparam logic [2:0] OFS_FLAGS = 3'h3;
  localparam logic [2:0] OFS_DATA = 3'h5;
  localparam int BIT_RX_FULL = 7;
  localparam int BIT_TX_EMPTY = 5;
  localparam int BIT_MODE_FAULT = 4;
  localparam int BIT_RX_IRQ_EN = 7;
  localparam int BIT_SYS_EN = 6;
  localparam int BIT_TX_IRQ_EN = 5;
  localparam int BIT_MASTER = 4;
  localparam int BIT_SEL_OUT_EN = 1;
  localparam int BIT_FAULT_EN = 4;
  localparam int PRESCALE_HI = 6;
  localparam int PRESCALE_LO = 4;
  localparam int RATE_HI = 2;
  localparam int RATE_LO = 0;
  localparam logic [7:0] BAUD_MASK = 8'h77;
  localparam logic [7:0] CONTROL_ONE_RESET = 8'h04;
  localparam logic [7:0] CONTROL_TWO_MASK = 8'h1b;
  localparam logic [7:0] CONTROL_TWO_RESET = 8'h00;
  localparam logic [7:0] BAUD_RESET = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [2:0] BITS_PER_BYTE = 3'h7;
  // transfer-complete needs 16 half-bit edges, counted as 4-bit value
  localparam logic [3:0] HALF_EDGES_LAST = 4'hf;
endpackage

//--- spi_rate_gen.sv
// prescaler and power-of-two divider making the master half-bit tick
`timescale 1ns/1ns
module spi_rate_gen
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic [2:0] prescale_select_i,
  input wire logic [2:0] rate_select_i,
  output logic half_tick_o
);
  typedef struct packed
  {
    logic [2:0] pre_cnt;
    logic [7:0] div_cnt;
    logic tick;
  } rate_state_t;
  rate_state_t st;
  rate_state_t next_st;
  logic [7:0] half_last;
  // divider counts half periods: ratio 2^(n+1) means 2^n prescaled ticks
  always_comb
  begin
    next_st = st;
    half_last = 8'((9'h001 << rate_select_i) - 9'h001);
    next_st.tick = 1'b0;
    if (!run_i)
    begin
      next_st.pre_cnt = 3'h0;
      next_st.div_cnt = 8'h00;
    end
    else if (st.pre_cnt >= prescale_select_i)
    begin
      next_st.pre_cnt = 3'h0;
      if (st.div_cnt >= half_last)
      begin
        next_st.div_cnt = 8'h00;
        next_st.tick = 1'b1;
      end
      else
        next_st.div_cnt = st.div_cnt + 8'h01;
    end
    else
      next_st.pre_cnt = st.pre_cnt + 3'h1;
  end
  // counters restart whenever the shifter is not running
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      st <= '0;
    else
      st <= next_st;
  end
  assign half_tick_o = st.tick;
endmodule

//--- spi_baud_status.sv
// baud generation, status flags, buffering and shifter of the serial port
`timescale 1ns/1ns
module spi_baud_status
  import spi_baud_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [spi_baud_pkg::ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic sel_n_i,
  input wire logic sclk_i,
  input wire logic miso_i,
  input wire logic mosi_i,
  output logic sclk_o,
  output logic mosi_o,
  output logic miso_o,
  output logic sel_n_o,
  output logic xfer_done_o,
  output logic load_shifter_o,
  output logic tx_irq_o,
  output logic rx_irq_o
);
  import spi_baud_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed
  {
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] baud;
    logic rx_full;
    logic tx_empty;
    logic mode_fault;
    logic rx_armed;
    logic tx_armed;
    logic fault_armed;
    logic [7:0] tx_buf;
    logic [7:0] rx_buf;
    logic [7:0] shifter;
    logic busy;
    logic [3:0] edges;
    logic samp_bit;
    logic [1:0] sel_sync;
    logic [1:0] sclk_sync;
    logic [1:0] miso_sync;
    logic [1:0] mosi_sync;
    logic sclk_prev;
    logic [2:0] slv_cnt;
    logic [7:0] rdata;
    logic sclk;
    logic mosi;
    logic miso;
    logic sel_n;
    logic done;
    logic load;
    logic tx_irq;
    logic rx_irq;
  } core_state_t;
  core_state_t st;
  core_state_t next_st;

  logic half_tick;
  logic enabled;
  logic master;
  logic fault_mode;
  logic sel_low;
  logic sclk_rise;
  logic complete;
  logic [7:0] rx_word;
  logic start_load;
  logic in_bit;

  assign enabled = st.ctl1[BIT_SYS_EN];
  assign master = st.ctl1[BIT_MASTER];
  assign fault_mode = master && st.ctl2[BIT_FAULT_EN]
    && !st.ctl1[BIT_SEL_OUT_EN];
  assign sel_low = !st.sel_sync[1];
  assign sclk_rise = st.sclk_sync[1] && !st.sclk_prev;

  // rate generator runs only while a master transfer is shifting
  spi_rate_gen rate_gen
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .run_i(enabled && master && st.busy),
    .prescale_select_i(st.baud[PRESCALE_HI:PRESCALE_LO]),
    .rate_select_i(st.baud[RATE_HI:RATE_LO]),
    .half_tick_o(half_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // whole next-state computation; one clean mode-0 format, msb first
  always_comb
  begin
    next_st = st;
    complete = 1'b0;
    start_load = 1'b0;
    rx_word = st.shifter;
    in_bit = 1'b0;
    next_st.done = 1'b0;
    next_st.load = 1'b0;
    // two-stage synchronisers on every pin input
    next_st.sel_sync = {st.sel_sync[0], sel_n_i};
    next_st.sclk_sync = {st.sclk_sync[0], sclk_i};
    next_st.miso_sync = {st.miso_sync[0], miso_i};
    next_st.mosi_sync = {st.mosi_sync[0], mosi_i};
    next_st.sclk_prev = st.sclk_sync[1];

    // register writes; the flag register has no write path
    if (wr_i)
    begin
      unique case (addr_i)
        OFS_CONTROL_ONE:
        begin
          next_st.ctl1 = wdata_i;
          if (st.fault_armed)
          begin
            next_st.mode_fault = 1'b0;
            next_st.fault_armed = 1'b0;
          end
        end
        OFS_CONTROL_TWO: next_st.ctl2 = wdata_i & CONTROL_TWO_MASK;
        OFS_BAUD: next_st.baud = wdata_i & BAUD_MASK;
        OFS_DATA:
        begin
          // write only counts after a flag read that saw room
          if (st.tx_armed && st.tx_empty && enabled)
          begin
            next_st.tx_buf = wdata_i;
            next_st.tx_empty = 1'b0;
            next_st.tx_armed = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end

    // reads: flag read arms the clears; data read may clear rx_full
    next_st.rdata = BYTE_ZERO;
    if (rd_i)
    begin
      unique case (addr_i)
        OFS_CONTROL_ONE: next_st.rdata = st.ctl1;
        OFS_CONTROL_TWO: next_st.rdata = st.ctl2;
        OFS_BAUD: next_st.rdata = st.baud;
        OFS_FLAGS:
        begin
          next_st.rdata = BYTE_ZERO;
          next_st.rdata[BIT_RX_FULL] = st.rx_full;
          next_st.rdata[BIT_TX_EMPTY] = st.tx_empty;
          next_st.rdata[BIT_MODE_FAULT] = st.mode_fault;
          next_st.rx_armed = st.rx_full;
          next_st.tx_armed = st.tx_empty;
          next_st.fault_armed = st.mode_fault;
        end
        OFS_DATA:
        begin
          next_st.rdata = st.rx_buf;
          if (st.rx_armed)
          begin
            next_st.rx_full = 1'b0;
            next_st.rx_armed = 1'b0;
          end
        end
        default: next_st.rdata = BYTE_ZERO;
      endcase
    end

    // shifting engine: master paced by half ticks, slave by its clock
    if (st.busy && master)
    begin
      if (half_tick)
      begin
        next_st.edges = st.edges + 4'h1;
        if (!st.edges[0])
        begin
          next_st.sclk = 1'b1;
          next_st.samp_bit = st.miso_sync[1];
        end
        else
        begin
          next_st.sclk = 1'b0;
          next_st.shifter = {st.shifter[6:0], st.samp_bit};
          next_st.mosi = st.shifter[6];
          if (st.edges == HALF_EDGES_LAST)
          begin
            complete = 1'b1;
            rx_word = {st.shifter[6:0], st.samp_bit};
          end
        end
      end
    end
    else if (st.busy && !master)
    begin
      // slave: external clock only, gated by its select
      next_st.sclk = 1'b0;
      if (sclk_rise && sel_low)
      begin
        in_bit = st.mosi_sync[1];
        next_st.shifter = {st.shifter[6:0], in_bit};
        next_st.miso = st.shifter[6];
        next_st.slv_cnt = st.slv_cnt + 3'h1;
        if (st.slv_cnt == BITS_PER_BYTE)
        begin
          complete = 1'b1;
          rx_word = {st.shifter[6:0], in_bit};
        end
      end
    end

    if (complete)
    begin
      next_st.busy = 1'b0;
      next_st.done = 1'b1;
      next_st.sel_n = 1'b1;
      // unread byte kept, new one dropped, no overrun flag
      // a clearing data read in this cycle frees the buffer: set wins
      if (!next_st.rx_full)
      begin
        next_st.rx_buf = rx_word;
        next_st.rx_full = 1'b1;
      end
    end

    // buffer to shifter: idle or just finished, and a byte waiting
    if (enabled && !st.tx_empty && (!st.busy || complete))
    begin
      start_load = 1'b1;
      next_st.shifter = st.tx_buf;
      next_st.busy = 1'b1;
      next_st.edges = 4'h0;
      next_st.slv_cnt = 3'h0;
      next_st.mosi = st.tx_buf[7];
      next_st.miso = st.tx_buf[7];
      next_st.sclk = 1'b0;
      next_st.sel_n = !(master && st.ctl2[BIT_FAULT_EN]
        && st.ctl1[BIT_SEL_OUT_EN]);
      next_st.load = start_load;
      next_st.tx_empty = 1'b1;
    end
    // empty buffer at completion: flag simply stays set

    // a write in this same cycle still wins over the load
    if (wr_i && addr_i == OFS_DATA && st.tx_armed && st.tx_empty
      && enabled)
      next_st.tx_empty = 1'b0;

    // mode fault: master with fault enable set and select output off, select input pulled low
    if (enabled && fault_mode && sel_low)
    begin
      next_st.mode_fault = 1'b1;
      next_st.busy = 1'b0;
      next_st.sclk = 1'b0;
    end

    // disable: abort, flush buffers, clear rx, set tx empty
    if (!next_st.ctl1[BIT_SYS_EN])
    begin
      next_st.busy = 1'b0;
      next_st.rx_full = 1'b0;
      next_st.tx_empty = 1'b1;
      next_st.edges = 4'h0;
      next_st.slv_cnt = 3'h0;
      next_st.sclk = 1'b0;
      next_st.sel_n = 1'b1;
      next_st.load = 1'b0;
    end

    // interrupt requests from next flag values
    next_st.tx_irq = next_st.tx_empty && next_st.ctl1[BIT_TX_IRQ_EN]
      && next_st.ctl1[BIT_SYS_EN];
    next_st.rx_irq = (next_st.rx_full || next_st.mode_fault)
      && next_st.ctl1[BIT_RX_IRQ_EN];
  end

  ////////////////////////////////////////////////////////////////////////////
  // one register stage for everything; reset to documented idle values
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      st <= '0;
      st.ctl1 <= CONTROL_ONE_RESET;
      st.ctl2 <= CONTROL_TWO_RESET;
      st.baud <= BAUD_RESET;
      st.tx_empty <= 1'b1;
      st.sel_n <= 1'b1;
      st.sel_sync <= 2'b11;
    end
    else
      st <= next_st;
  end

  assign rdata_o = st.rdata;
  assign sclk_o = st.sclk;
  assign mosi_o = st.mosi;
  assign miso_o = st.miso;
  assign sel_n_o = st.sel_n;
  assign xfer_done_o = st.done;
  assign load_shifter_o = st.load;
  assign tx_irq_o = st.tx_irq;
  assign rx_irq_o = st.rx_irq;
endmodule

//--- spi_baud_status_sva.sv
// assertion checker for the serial baud and status block
`timescale 1ns/1ns
module spi_baud_status_sva
  import spi_baud_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [spi_baud_pkg::ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic sclk_o,
  input wire logic sel_n_o,
  input wire logic xfer_done_o,
  input wire logic load_shifter_o,
  input wire logic tx_irq_o,
  input wire logic rx_irq_o
);
  typedef struct packed {logic [7:0] c1; logic [7:0] c2;} shadow_t;
  shadow_t sh;
  shadow_t next_sh;
  logic sel_ok;
  //////////////////////////////////////////////////////////////////////////
  // shadow of the control registers, built from bus writes only
  always_comb
  begin
    next_sh = sh;
    if (wr_i && addr_i == OFS_CONTROL_ONE)
      next_sh.c1 = wdata_i;
    if (wr_i && addr_i == OFS_CONTROL_TWO)
      next_sh.c2 = wdata_i;
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      sh <= {CONTROL_ONE_RESET, CONTROL_TWO_RESET};
    else
      sh <= next_sh;
  end
  // irq checks allow one cycle of lag, the outputs are registered
  assign sel_ok = sh.c1[BIT_MASTER] & sh.c1[BIT_SEL_OUT_EN] & sh.c2[4];
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence flag_read;
    rd_i && addr_i == OFS_FLAGS;
  endsequence
  rdata_idle_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside read");
  flags_zero_a: assert property
    (flag_read |=> (rdata_o & 8'h4f) == 8'h00)
    else $error("unused flag bits not zero");
  tx_irq_a: assert property
    (tx_irq_o |-> (sh.c1[BIT_TX_IRQ_EN] || $past(sh.c1[BIT_TX_IRQ_EN])))
    else $error("transmit irq without enable");
  rx_irq_a: assert property
    (rx_irq_o |-> (sh.c1[BIT_RX_IRQ_EN] || $past(sh.c1[BIT_RX_IRQ_EN])))
    else $error("receive irq without enable");
  load_gap_a: assert property
    (load_shifter_o |=> !load_shifter_o [*8])
    else $error("loads closer than a byte");
  done_gap_a: assert property (xfer_done_o |=> !xfer_done_o [*8])
    else $error("completions closer than a byte");
  sel_out_a: assert property
    (!sel_n_o |-> sel_ok || $past(sel_ok) || $past(sel_ok, 2))
    else $error("select driven outside output mode");
  slave_quiet_a: assert property
    (!sh.c1[BIT_MASTER] [*3] |-> !sclk_o)
    else $error("bit clock runs in slave mode");
endmodule
bind spi_baud_status spi_baud_status_sva spi_baud_status_sva_inst
(
  .ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .sclk_o(sclk_o),
  .sel_n_o(sel_n_o),
  .xfer_done_o(xfer_done_o),
  .load_shifter_o(load_shifter_o),
  .tx_irq_o(tx_irq_o),
  .rx_irq_o(rx_irq_o)
);

//--- spi_echo_model.sv
// echoing serial peripheral on the far side of the link
`timescale 1ns/1ns
module spi_echo_model
(
  input wire logic sclk_i,
  input wire logic mosi_i,
  output logic miso_o
);
  // first byte returned is this seed, later ones echo the previous byte
  logic [7:0] shreg = 8'h5a;
  // starts at the seed msb so the first bit stands before any edge
  logic out_bit = 1'b0;
  // sample on rising edge, present next bit on falling edge
  always @(posedge sclk_i)
    shreg <= {shreg[6:0], mosi_i};
  always @(negedge sclk_i)
    out_bit <= shreg[7];
  assign miso_o = out_bit;
endmodule

//--- testbench.sv
// self-checking bench for the serial baud and status block
`timescale 1ns/1ns
module testbench;
  import spi_baud_pkg::*;
  typedef struct {logic [2:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] rdata_o;
  logic wr_i = 1'b0, rd_i = 1'b0, sel_n_i = 1'b1, sclk_i = 1'b0;
  logic mosi_i = 1'b0, miso_i, sclk_o, mosi_o, miso_o, sel_n_o;
  logic xfer_done_o, load_shifter_o, tx_irq_o, rx_irq_o;
  int error_cnt = 0, comparisons = 0, cyc = 0, loads = 0, n, hi;
  row_t rows [5] = '{'{OFS_BAUD, 8'h77, 8'h77}, '{OFS_BAUD, 8'hff, 8'h77},
    '{OFS_CONTROL_TWO, 8'hff, 8'h1b}, '{OFS_FLAGS, 8'hff, 8'h20},
    '{3'h4, 8'hff, 8'h00}};
  logic [7:0] slave_rx = 8'h96, slave_tx = 8'hc3;
  spi_baud_status spi_baud_status_inst
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .sel_n_i(sel_n_i),
    .sclk_i(sclk_i),
    .miso_i(miso_i),
    .mosi_i(mosi_i),
    .sclk_o(sclk_o),
    .mosi_o(mosi_o),
    .miso_o(miso_o),
    .sel_n_o(sel_n_o),
    .xfer_done_o(xfer_done_o),
    .load_shifter_o(load_shifter_o),
    .tx_irq_o(tx_irq_o),
    .rx_irq_o(rx_irq_o)
  );
  spi_echo_model spi_echo_model_inst (.sclk_i(sclk_o), .mosi_i(mosi_o),
    .miso_o(miso_i));
  always #4 ref_clk_i = ~ref_clk_i;
  //////////////////////////////////////////////////////////////////////////
  // cycle count, load count and hang guard
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (load_shifter_o)
      loads <= loads + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, e);
  endtask
  // pick the watched output: 0 bit clock, 1 load pulse, else done pulse
  function automatic logic probe(input int which);
    case (which)
      0: probe = sclk_o;
      1: probe = load_shifter_o;
      default: probe = xfer_done_o;
    endcase
  endfunction
  // bounded wait for a level, n holds the cycles spent
  task automatic wait_lv(input int which, input logic v, input int lim);
    n = 0;
    while (probe(which) !== v && n < lim)
    begin
      @(posedge ref_clk_i);
      #1 n++;
    end
  endtask
  // half-bit high and low phases of the master bit clock
  task automatic measure(input int half);
    wait_lv(0, 1'b0, 300);
    wait_lv(0, 1'b1, 300);
    wait_lv(0, 1'b0, 300);
    hi = n;
    wait_lv(0, 1'b1, 300);
    check(8'(hi), 8'(half));
    check(8'(n), 8'(half));
  endtask
  // one slave bit: clock low and data set, our output checked, clock high
  // each level stands over two synchroniser stages plus the edge detector
  task automatic slave_bit(input logic din, input logic exp);
    @(posedge ref_clk_i);
    mosi_i <= din;
    sclk_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1 check({7'h0, miso_o}, {7'h0, exp});
    @(posedge ref_clk_i);
    sclk_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(OFS_CONTROL_ONE, CONTROL_ONE_RESET);
    rd(OFS_BAUD, BAUD_RESET);
    rd(OFS_FLAGS, 8'h20);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    wr(OFS_CONTROL_TWO, 8'h00);
    wr(OFS_CONTROL_ONE, 8'h50);
    wr(OFS_BAUD, 8'h11);
    rd(OFS_FLAGS, 8'h20);
    wr(OFS_DATA, 8'ha5);
    wait_lv(1, 1'b1, 4);
    check(8'(n > 2), 8'h00);
    rd(OFS_FLAGS, 8'h20);
    wr(OFS_DATA, 8'h3c);
    rd(OFS_FLAGS, 8'h00);
    wr(OFS_DATA, 8'h77);
    measure(4);
    rd(OFS_BAUD, 8'h11);
    wait_lv(2, 1'b1, 100);
    check({7'h0, xfer_done_o}, 8'h01);
    wait_lv(1, 1'b1, 4);
    check({7'h0, load_shifter_o}, 8'h01);
    rd(OFS_FLAGS, 8'ha0);
    wait_lv(2, 1'b1, 100);
    repeat (10) @(posedge ref_clk_i);
    check(8'(loads), 8'h02);
    rd(OFS_FLAGS, 8'ha0);
    rd(OFS_DATA, 8'h5a);
    rd(OFS_FLAGS, 8'h20);
    wr(OFS_CONTROL_ONE, 8'h70);
    repeat (3) @(posedge ref_clk_i);
    check({7'h0, tx_irq_o}, 8'h01);
    wr(OFS_BAUD, 8'h72);
    rd(OFS_FLAGS, 8'h20);
    wr(OFS_DATA, 8'h0f);
    measure(32);
    wait_lv(2, 1'b1, 600);
    wr(OFS_CONTROL_ONE, 8'hd0);
    repeat (3) @(posedge ref_clk_i);
    check({7'h0, tx_irq_o}, 8'h00);
    check({7'h0, rx_irq_o}, 8'h01);
    // far side echoes the second byte back in the third transfer
    rd(OFS_DATA, 8'h3c);
    wr(OFS_CONTROL_ONE, 8'h10);
    rd(OFS_FLAGS, 8'h20);
    check({7'h0, rx_irq_o}, 8'h00);
    // automatic select output: fault input must stay inert; with select output off it sets the fault
    wr(OFS_CONTROL_TWO, 8'h10);
    wr(OFS_CONTROL_ONE, 8'h52);
    wr(OFS_BAUD, 8'h00);
    rd(OFS_FLAGS, 8'h20);
    wr(OFS_DATA, 8'h81);
    wait_lv(1, 1'b1, 4);
    check({7'h0, sel_n_o}, 8'h00);
    wait_lv(2, 1'b1, 100);
    sel_n_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rd(OFS_FLAGS, 8'ha0);
    wr(OFS_CONTROL_ONE, 8'h50);
    repeat (6) @(posedge ref_clk_i);
    rd(OFS_FLAGS, 8'hb0);
    sel_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    wr(OFS_CONTROL_ONE, 8'h50);
    rd(OFS_FLAGS, 8'ha0);
    // slave transfer, timed only by the external clock
    wr(OFS_CONTROL_ONE, 8'h00);
    wr(OFS_CONTROL_ONE, 8'h40);
    rd(OFS_FLAGS, 8'h20);
    wr(OFS_DATA, slave_tx);
    sel_n_i <= 1'b0;
    for (int i = 7; i >= 0; i--)
      slave_bit(slave_rx[i], slave_tx[i]);
    wait_lv(2, 1'b1, 8);
    check({7'h0, xfer_done_o}, 8'h01);
    sel_n_i <= 1'b1;
    rd(OFS_FLAGS, 8'ha0);
    rd(OFS_DATA, slave_rx);
    check(8'(loads), 8'h05);
    finish_test();
  end
endmodule
